//--- unit_io_pkg.sv
// unit_io_pkg: shared constants for the unit i/o terminal link
// assumes a single 100 MHz clock domain
package unit_io_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYCLE_TIME_NS = 1750;
	localparam int CYCLE_CLKS = CYCLE_TIME_NS / CLK_PERIOD_NS;
	localparam int PHASE_A_CLK = 35;
	localparam int PHASE_FOUR_CLK = 53;
	localparam int PHASE_B_CLK = 140;
	localparam int OPND_W = 16;
	localparam int UNIT_W = 6;
	localparam int WORD_W = 16;
	localparam int INDIRECT_BIT = 5;
	localparam int MAP_BIT = 6;
	localparam int ADDR_W = 14;
	localparam logic [15:0] COND_BUSY = 16'h0001;
	localparam logic [15:0] COND_PARITY = 16'h0002;
	localparam logic [15:0] COND_INOP = 16'h0004;
	localparam logic [15:0] COND_NOT_BUSY = 16'h0008;
	localparam logic [15:0] COND_EOF = 16'h0010;
	localparam logic [15:0] COND_CUSTOM = 16'h0020;
	localparam int COND_BUSY_IDX = 0;
	localparam int COND_PARITY_IDX = 1;
	localparam int COND_INOP_IDX = 2;
	localparam int COND_NOT_BUSY_IDX = 3;
	localparam int COND_EOF_IDX = 4;
	localparam int COND_CUSTOM_IDX = 5;
	localparam int COND_N = 6;
	localparam int DATA_HERE_CLKS = 8;
endpackage

//--- unit_io_if.sv
// unit_io_if: signals between mainframe i/o control and unit terminal
// assumes all signals active high, synchronous to one clock
`timescale 1ns/1ps
interface unit_io_if;
	import unit_io_pkg::*;
	logic command_to_unit_instr;
	logic test_unit_instr;
	logic wait_flag;
	logic [UNIT_W-1:0] unit_code;
	logic instr_sync;
	logic phase_pulse_a;
	logic phase_pulse_b;
	logic data_here;
	logic [WORD_W-1:0] io_bus;
	logic unit_test_return;
	logic unit_sync_return;
	logic unit_data_accepted;
	modport host (
		output command_to_unit_instr, test_unit_instr, wait_flag, unit_code,
		output instr_sync, phase_pulse_a, phase_pulse_b, data_here, io_bus,
		input unit_test_return, unit_sync_return, unit_data_accepted
	);
	modport unit (
		input command_to_unit_instr, test_unit_instr, wait_flag, unit_code,
		input instr_sync, phase_pulse_a, phase_pulse_b, data_here, io_bus,
		output unit_test_return, unit_sync_return, unit_data_accepted
	);
endinterface

//--- unit_terminal.sv
// unit_terminal: peripheral side data terminal for command and test instructions
// assumes the mainframe end drives the interface; unit logic on plain ports
// Operation
// - mainframe asserts command line during instruction
// - instruction sync releases return flip-flops
// - next phase pulse clocks both; ready sets test
// - skip mode: pulse always sets sync return
// - wait mode: sync return follows test return
// - ready resampled each pulse; test forces sync
// - mainframe skips on test return
// - sync return clears mainframe hold latch
// - data here releases accept flip-flops
// - command ready from instr, select, data here
// - pulse gated out as command strobe
// - unit accept delay is tolerated
// - pulse after accept sets command accept
// - set command accept drives data accepted
// - test operand selects condition to test
// - test instruction always skip mode, ready
// - map bit supplies top address bit
// - test instruction cycle counts
// - sync removal clears both return flip-flops
// - test return on true condition, then accept
`timescale 1ns/1ps
module unit_terminal #(
	parameter logic [5:0] UNIT_NUMBER = 6'h03
) (
	// clock and control
	input wire logic I_MCLK,
	input wire logic I_RESETN,
	input wire logic I_CE,
	// link
	unit_io_if.unit LINK,
	// unit side
	input wire logic I_UNIT_READY,
	input wire logic I_CMD_ACCEPTED,
	input wire logic [unit_io_pkg::COND_N-1:0] I_CONDITIONS,
	output logic O_CMD_READY,
	output logic O_CMD_READY_N,
	output logic O_CMD_STROBE,
	output logic [unit_io_pkg::WORD_W-1:0] O_FUNCTION
);
	import unit_io_pkg::*;

	logic test_return_ff_r;
	logic sync_return_ff_r;
	logic command_accept_ff_r;
	logic data_accept_ff_r;
	logic test_accept_r;
	logic [WORD_W-1:0] function_r;
	logic pulse;
	logic this_unit;
	logic sel;
	logic any_cmd;
	logic cond_true;

	// ************************************************************
	// select and pulse decode
	// ************************************************************
	// pulses as enables
	assign pulse = I_CE && (LINK.phase_pulse_a || LINK.phase_pulse_b);
	assign this_unit = (LINK.unit_code == UNIT_NUMBER);
	assign any_cmd = LINK.command_to_unit_instr || LINK.test_unit_instr;
	assign sel = any_cmd && this_unit && LINK.instr_sync;

	function automatic logic cond_match(input logic [WORD_W-1:0] opnd,
		input logic [COND_N-1:0] c);
		cond_match = |(opnd[COND_N-1:0] & c);
	endfunction
	assign cond_true = cond_match(LINK.io_bus, I_CONDITIONS);

	// ************************************************************
	// test and sync return
	// ************************************************************
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN || !sel) begin
			test_return_ff_r <= 1'b0;
		end else if (pulse && LINK.command_to_unit_instr && I_UNIT_READY) begin
			test_return_ff_r <= 1'b1;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN || !sel) begin
			sync_return_ff_r <= 1'b0;
		end else if (I_CE && test_return_ff_r) begin
			sync_return_ff_r <= 1'b1;
		end else if (pulse && (LINK.test_unit_instr || !LINK.wait_flag)) begin
			sync_return_ff_r <= 1'b1;
		end
	end

	// ************************************************************
	// command transfer
	// ************************************************************
	// command ready decode
	assign O_CMD_READY = LINK.command_to_unit_instr && this_unit && LINK.data_here;
	assign O_CMD_READY_N = !O_CMD_READY;
	assign O_CMD_STROBE = pulse && O_CMD_READY && !command_accept_ff_r;

	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN || !LINK.data_here) begin
			command_accept_ff_r <= 1'b0;
			data_accept_ff_r <= 1'b0;
		end else if (pulse && O_CMD_READY && I_CMD_ACCEPTED) begin
			command_accept_ff_r <= 1'b1;
			data_accept_ff_r <= 1'b1;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			function_r <= 16'h0000;
		end else if (O_CMD_STROBE) begin
			function_r <= LINK.io_bus;
		end
	end
	assign O_FUNCTION = function_r;

	// ************************************************************
	// test instruction
	// ************************************************************
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN || !LINK.data_here) begin
			test_accept_r <= 1'b0;
		end else if (pulse && LINK.test_unit_instr && this_unit) begin
			test_accept_r <= 1'b1;
		end
	end

	// ************************************************************
	// returns
	// ************************************************************
	// test forces sync out
	assign LINK.unit_sync_return = sync_return_ff_r || test_return_ff_r;
	assign LINK.unit_test_return = test_return_ff_r ||
		(LINK.test_unit_instr && this_unit && LINK.data_here && cond_true);
	assign LINK.unit_data_accepted = data_accept_ff_r || test_accept_r;
endmodule // unit_terminal

//--- mainframe_io.sv
// mainframe_io: mainframe i/o control and timing for command and test
// assumes unit terminal on the link; software uses a plain register port
`timescale 1ns/1ps
module mainframe_io (
	// clock and control
	input wire logic I_MCLK,
	input wire logic I_RESETN,
	input wire logic I_CE,
	// register port
	input wire logic [1:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	// link
	unit_io_if.host LINK
);
	import unit_io_pkg::*;

	typedef enum {ST_IDLE, ST_SYNC, ST_DATA, ST_DONE} state_t;
	state_t state_r;
	logic [7:0] tick_r;
	logic [15:0] word1_r;
	logic [15:0] word2_r;
	logic [15:0] rdata_r;
	logic go_r;
	logic busy_r;
	logic skip_r;
	logic [1:0] pc_adv_r;
	logic [15:0] addr_r;
	logic is_test;

	assign is_test = word1_r[15];
	// ************************************************************
	// cycle timing
	// ************************************************************
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			tick_r <= 8'h00;
		end else if (I_CE) begin
			tick_r <= (tick_r == 8'(CYCLE_CLKS - 1)) ? 8'h00 : tick_r + 8'h01;
		end
	end
	assign LINK.phase_pulse_a = I_CE && (tick_r == 8'(PHASE_A_CLK));
	assign LINK.phase_pulse_b = I_CE && (tick_r == 8'(PHASE_B_CLK));

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			word1_r <= 16'h0000;
			word2_r <= 16'h0000;
			go_r <= 1'b0;
		end else begin
			go_r <= 1'b0;
			if (I_WR && I_ADDR == 2'h0) word1_r <= I_WDATA;
			if (I_WR && I_ADDR == 2'h1) word2_r <= I_WDATA;
			if (I_WR && I_ADDR == 2'h2) go_r <= I_WDATA[0];
		end
	end
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			rdata_r <= 16'h0000;
		end else begin
			case (I_ADDR)
				2'h0: rdata_r <= word1_r;
				2'h1: rdata_r <= word2_r;
				2'h2: rdata_r <= {12'h000, pc_adv_r, skip_r, busy_r};
				default: rdata_r <= addr_r;
			endcase
		end
	end
	assign O_RDATA = rdata_r;

	// ************************************************************
	// instruction sequence
	// ************************************************************
	always_ff @(posedge I_MCLK) begin
		if (!I_RESETN) begin
			state_r <= ST_IDLE;
			busy_r <= 1'b0;
			skip_r <= 1'b0;
			pc_adv_r <= 2'h0;
			addr_r <= 16'h0000;
		end else if (I_CE) begin
			case (state_r)
				ST_IDLE: begin
					if (go_r) begin
						busy_r <= 1'b1;
						skip_r <= 1'b0;
						addr_r <= {1'b0, word1_r[MAP_BIT], word2_r[ADDR_W-1:0]};
						state_r <= ST_SYNC;
					end
				end
				ST_SYNC: begin
					if (LINK.unit_sync_return && tick_r == 8'(PHASE_FOUR_CLK)) begin
						skip_r <= LINK.unit_test_return;
						if (!is_test && !LINK.unit_test_return) begin
							pc_adv_r <= 2'h1;
							state_r <= ST_DONE;
						end else begin
							state_r <= ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (LINK.unit_data_accepted) begin
						if (is_test) skip_r <= LINK.unit_test_return;
						pc_adv_r <= (is_test && !LINK.unit_test_return) ? 2'h1 : 2'h2;
						state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					busy_r <= 1'b0;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign LINK.command_to_unit_instr = busy_r && !is_test;
	assign LINK.test_unit_instr = busy_r && is_test;
	assign LINK.wait_flag = word1_r[14] && !is_test;
	assign LINK.unit_code = word1_r[UNIT_W-1:0];
	assign LINK.instr_sync = (state_r == ST_SYNC);
	assign LINK.data_here = (state_r == ST_DATA);
	assign LINK.io_bus = word2_r;
endmodule // mainframe_io

//--- uio_link_sva.sv
// uio_link_sva: protocol checks on the unit link
// assumes link signals active high on one clock
`timescale 1ns/1ps
module uio_link_sva #(
	parameter logic [5:0] UNIT = 6'h03
) (
	// clock and control
	input wire logic I_MCLK,
	input wire logic I_RESETN,
	input wire logic I_CE,
	// link
	input wire logic command_to_unit_instr,
	input wire logic test_unit_instr,
	input wire logic wait_flag,
	input wire logic [unit_io_pkg::UNIT_W-1:0] unit_code,
	input wire logic instr_sync,
	input wire logic phase_pulse_a,
	input wire logic phase_pulse_b,
	input wire logic data_here,
	input wire logic unit_test_return,
	input wire logic unit_sync_return,
	input wire logic unit_data_accepted
);
	import unit_io_pkg::*;
	// ****
	// checks
	// ****
	wire logic tick = I_CE && (phase_pulse_a || phase_pulse_b);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RESETN);
	sequence skip_tick;
		instr_sync && unit_code == UNIT && tick && (test_unit_instr || !wait_flag);
	endsequence
	sequence idle_two;
		!data_here [*2];
	endsequence
	sync_instr_a: assert property (
		instr_sync |-> command_to_unit_instr || test_unit_instr) else $error("sync alone");
	skip_sync_a: assert property (
		skip_tick |=> unit_sync_return) else $error("no sync return");
	wait_sync_a: assert property (
		command_to_unit_instr && wait_flag |-> unit_sync_return == unit_test_return)
		else $error("wait sync early");
	test_forces_a: assert property (
		command_to_unit_instr && unit_test_return |-> unit_sync_return)
		else $error("test without sync");
	sync_drop_a: assert property (
		$fell(instr_sync) |=> !unit_sync_return) else $error("sync return stuck");
	data_here_a: assert property (
		$rose(unit_test_return) && command_to_unit_instr |-> ##[1:400] data_here)
		else $error("no data here");
	accept_cause_a: assert property (
		$rose(unit_data_accepted) |-> data_here) else $error("accept without data");
	accept_drop_a: assert property (
		idle_two |-> !unit_data_accepted) else $error("accept stuck");
	teu_test_a: assert property (
		test_unit_instr && unit_test_return |-> data_here) else $error("test early");
endmodule // uio_link_sva

//--- peripheral_command_test_terminal_tb.sv
// tb: both link ends driven through registers and unit pins
// assumes unit number 3, status {pc_adv, skip, busy}
`timescale 1ns/1ps
module peripheral_command_test_terminal_tb;
	import unit_io_pkg::*;
	logic I_MCLK = 0, I_RESETN = 0, I_WR = 0, I_RD = 0;
	logic I_UNIT_READY = 0, I_CMD_ACCEPTED = 0;
	logic [1:0] I_ADDR = 0;
	logic [15:0] I_WDATA = 0, O_RDATA, O_FUNCTION, st;
	logic [COND_N-1:0] I_CONDITIONS = 0;
	logic O_CMD_READY, O_CMD_READY_N, O_CMD_STROBE;
	int err_total = 0, n_tests = 0, n_stb = 0, dly = 0, acc_dly = 1;
	unit_io_if lnk ();
	mainframe_io u_mainframe_io (.I_MCLK, .I_RESETN, .I_CE(1'b1), .I_ADDR, .I_WDATA,
		.I_WR, .I_RD, .O_RDATA, .LINK(lnk.host));
	unit_terminal u_unit_terminal (.I_MCLK, .I_RESETN, .I_CE(1'b1), .LINK(lnk.unit),
		.I_UNIT_READY, .I_CMD_ACCEPTED, .I_CONDITIONS, .O_CMD_READY, .O_CMD_READY_N,
		.O_CMD_STROBE, .O_FUNCTION);
	uio_link_sva u_uio_link_sva (.I_MCLK, .I_RESETN, .I_CE(1'b1),
		.command_to_unit_instr(lnk.command_to_unit_instr),
		.test_unit_instr(lnk.test_unit_instr), .wait_flag(lnk.wait_flag),
		.unit_code(lnk.unit_code), .instr_sync(lnk.instr_sync),
		.phase_pulse_a(lnk.phase_pulse_a), .phase_pulse_b(lnk.phase_pulse_b),
		.data_here(lnk.data_here), .unit_test_return(lnk.unit_test_return),
		.unit_sync_return(lnk.unit_sync_return),
		.unit_data_accepted(lnk.unit_data_accepted));
	initial forever #5 I_MCLK = ~I_MCLK;
	// ****
	// helpers
	// ****
	task automatic end_sim();
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", s, e, g);
			err_total++;
		end
	endtask
	always @(posedge I_MCLK) begin
		if (O_CMD_STROBE === 1'b1) begin
			chk("cmd ready", 16'h0002, {14'h0, O_CMD_READY, O_CMD_READY_N});
			n_stb <= n_stb + 1;
			dly <= acc_dly;
		end else if (dly > 0)
			dly <= dly - 1;
		I_CMD_ACCEPTED <= lnk.data_here && (I_CMD_ACCEPTED || dly == 1);
	end
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge I_MCLK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_MCLK);
		I_WR <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [15:0] q);
		@(posedge I_MCLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_MCLK);
		I_RD <= 1'b0;
		@(posedge I_MCLK);
		q = O_RDATA;
	endtask
	task automatic go(input logic [15:0] w1, w2);
		wr(2'h0, w1);
		wr(2'h1, w2);
		wr(2'h2, 16'h0001);
	endtask
	task automatic done();
		for (int i = 0; i < 2000; i++) begin
			rd(2'h2, st);
			if (st[0] === 1'b0)
				return;
		end
		err_total++;
		end_sim();
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_cmd(input logic rdy, input int d, input logic [2:0] e);
		int b;
		b = n_stb;
		acc_dly = d;
		I_UNIT_READY <= rdy;
		go(16'h0003, 16'hA5C3);
		done();
		chk("cmd status", {13'h0, e}, {13'h0, st[3:1]});
		chk("strobes", rdy ? 16'h0002 : 16'h0000, 16'(n_stb - b));
		if (rdy)
			chk("function", 16'hA5C3, O_FUNCTION);
	endtask
	task automatic t_wait();
		int b;
		b = n_stb;
		I_UNIT_READY <= 1'b0;
		go(16'h4003, 16'h0F0F);
		repeat (400) @(posedge I_MCLK);
		rd(2'h2, st);
		chk("wait busy", 16'h0001, {15'h0, st[0]});
		I_UNIT_READY <= 1'b1;
		done();
		chk("wait func", 16'h0F0F, O_FUNCTION);
		chk("wait stb", 16'h0002, 16'(n_stb - b));
	endtask
	task automatic t_test();
		I_UNIT_READY <= 1'b0;
		for (int i = 0; i < COND_N; i++) begin
			I_CONDITIONS <= COND_N'(1 << i);
			go(16'h8003, 16'(1 << i));
			done();
			chk("hit", 16'h0005, {13'h0, st[3:1]});
			rd(2'h3, st);
			chk("address", 16'(1 << i), st);
			go(16'h8003, 16'(1 << ((i + 1) % COND_N)));
			done();
			chk("miss", 16'h0002, {13'h0, st[3:1]});
		end
	endtask
	initial begin
		repeat (12) @(posedge I_MCLK);
		I_RESETN <= 1'b1;
		t_cmd(1'b1, 1, 3'h5);
		t_cmd(1'b1, 20, 3'h5);
		t_cmd(1'b0, 1, 3'h2);
		t_wait();
		t_test();
		end_sim();
	end
endmodule // peripheral_command_test_terminal_tb
